// >>> dv/mfd_decoder_properties.sv
// Concurrent checks on the microword decoder ports
`timescale 1ns/1ps
module mfd_decoder_properties #(
  parameter W_BITS = 38
) (
  // Clock, reset and sequencer side
  input wire              ref_clk, rstn, step_end, byte_op, odd_byte,
  input wire [W_BITS-1:0] rom_word,
  input wire [7:0]        test_or_bits, next_step_pointer,
  // Datapath side
  input wire [1:0]        shift_or_bits, scratch_op_select, a_path_select,
  input wire [1:0]        shift_reg_op_select, scratch_addr_source,
  input wire [1:0]        bus_ctl_type,
  input wire [3:0]        bus_addr_low, scratch_addr_literal, scratch_addr,
  input wire [15:0]       opcode, shift_reg_data, shift_reg_widened,
  input wire [5:0]        alu_ctrl,
  // Decoded controls
  input wire              scratch_write, scratch_write_high, service_enable,
  input wire              scratch_extra_enable, sign_widen_enable,
  input wire              opcode_latch_load, aux_rom_enable, flag_load,
  input wire              dest_branch_strobe, status_word_load,
  input wire              bus_fault_halt_enable, stack_check_enable,
  input wire              transfer_active, bus_sync_gate, increment_inhibit_n
);
  // ==========================================
  // Word at the fetch edge and pointer due after a step
  logic [W_BITS-1:0] pw;
  logic [7:0]        ptr_exp;
  always @(posedge ref_clk) begin
    pw      <= rom_word;
    ptr_exp <= (rom_word[7:0] + ((rom_word[10] && byte_op) ?
               8'h02 + {7'h0, odd_byte} : 8'h00)) | test_or_bits;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Step taken, fetch edge, then outputs show the word
  sequence s_fetch;
    step_end ##2 1'b1;
  endsequence
  // ==========================================
  // Assertions
  a_next_latch: assert property (
    step_end |=> next_step_pointer == ptr_exp) else $error("bad pointer");
  a_scratch_op: assert property (
    s_fetch |-> scratch_op_select == pw[9:8] && scratch_write_high == pw[9]
    && scratch_write == (pw[9:8] != 2'b00)
    && scratch_extra_enable == (pw[9:8] == 2'b10)) else $error("bad scratch");
  a_strobe_hot: assert property (
    s_fetch |-> {dest_branch_strobe, flag_load, bus_fault_halt_enable,
    status_word_load, stack_check_enable} == {pw[16:14] == 3'h2,
    pw[16:14] == 3'h3, pw[16:14] == 3'h4, pw[16:14] == 3'h5,
    pw[16:14] == 3'h6}) else $error("bad strobe");
  a_shift_or: assert property (
    s_fetch |-> shift_reg_op_select == (pw[13:12] | shift_or_bits))
    else $error("bad shift mode");
  a_xfer_type: assert property (
    s_fetch |-> transfer_active == pw[17] && bus_ctl_type == pw[19:18])
    else $error("bad transfer");
  a_byte_gate: assert property (
    s_fetch |-> increment_inhibit_n == !(pw[20] && byte_op)
    && bus_sync_gate == (pw[17] && (pw[20] || !byte_op)))
    else $error("bad byte gate");
  a_path_misc: assert property (
    s_fetch |-> a_path_select == pw[22:21] && service_enable == pw[11]
    && aux_rom_enable == pw[36] && opcode_latch_load == pw[37]
    && sign_widen_enable == pw[23] && scratch_addr_source == pw[31:30]
    && scratch_addr_literal == pw[35:32] && alu_ctrl == pw[29:24])
    else $error("bad controls");
  a_addr_mux: assert property (
    scratch_addr == (scratch_addr_source == 2'h0 ? bus_addr_low :
    scratch_addr_source == 2'h1 ? {1'b0, opcode[8:6]} :
    scratch_addr_source == 2'h2 ? {1'b0, opcode[2:0]} :
    scratch_addr_literal)) else $error("bad scratch address");
  a_sign_copy: assert property (
    shift_reg_widened == (sign_widen_enable ? {{8{shift_reg_data[7]}},
    shift_reg_data[7:0]} : shift_reg_data)) else $error("bad widen");
endmodule

bind mfd_microword_decoder mfd_decoder_properties #(.W_BITS(W_BITS))
  mfd_decoder_properties_i (.ref_clk, .rstn, .step_end, .byte_op,
  .odd_byte, .rom_word, .test_or_bits, .next_step_pointer, .shift_or_bits,
  .scratch_op_select, .a_path_select, .shift_reg_op_select,
  .scratch_addr_source, .bus_ctl_type, .bus_addr_low, .scratch_addr_literal,
  .scratch_addr, .opcode, .shift_reg_data, .shift_reg_widened,
  .scratch_write, .scratch_write_high, .service_enable,
  .scratch_extra_enable, .sign_widen_enable, .opcode_latch_load,
  .aux_rom_enable, .flag_load, .dest_branch_strobe, .status_word_load,
  .bus_fault_halt_enable, .stack_check_enable, .transfer_active,
  .bus_sync_gate, .increment_inhibit_n, .alu_ctrl);

// >>> dv/mfd_microword_decoder_tb_top.sv
// Self-checking bench for the microword field decoder
`timescale 1ns/1ps
`include "mfd_defs.vh"
module mfd_microword_decoder_tb_top;
  // ==========================================
  // Stimulus and observed signals
  logic ref_clk = 1'b0, rstn = 1'b0, step_end = 1'b0, byte_op = 1'b0;
  logic odd_byte = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] test_or_bits = 8'h00;
  logic [1:0] shift_or_bits = 2'h0;
  logic [3:0] bus_addr_low = 4'h9, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] opcode = 16'h01c5, shift_reg_data = 16'h0080;
  logic [31:0] s_axi_wdata = 32'h0;
  wire [37:0] rom_word;
  wire [7:0] next_step_pointer;
  wire [1:0] scratch_op_select, shift_reg_op_select, a_path_select;
  wire [1:0] scratch_addr_source, bus_ctl_type, s_axi_bresp, s_axi_rresp;
  wire [3:0] scratch_addr_literal, scratch_addr;
  wire [15:0] shift_reg_widened;
  wire [5:0] alu_ctrl;
  wire [31:0] s_axi_rdata;
  wire scratch_write, scratch_write_high, scratch_extra_enable, flag_load;
  wire sign_widen_enable, opcode_latch_load, aux_rom_enable, service_enable;
  wire dest_branch_strobe, bus_fault_halt_enable, status_word_load;
  wire stack_check_enable, transfer_active, bus_sync_gate, s_axi_wready;
  wire increment_inhibit_n, s_axi_awready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  int  err_total = 0;
  int  checked = 0;

  mfd_microword_decoder mfd_microword_decoder_i (
    .ref_clk, .rstn, .rom_word, .step_end, .test_or_bits, .byte_op,
    .odd_byte, .next_step_pointer, .shift_or_bits, .bus_addr_low, .opcode,
    .shift_reg_data, .scratch_op_select, .scratch_write,
    .scratch_write_high, .scratch_extra_enable, .shift_reg_op_select,
    .a_path_select, .sign_widen_enable, .shift_reg_widened, .alu_ctrl,
    .scratch_addr_source, .scratch_addr_literal, .scratch_addr,
    .opcode_latch_load, .aux_rom_enable, .service_enable,
    .dest_branch_strobe, .flag_load, .bus_fault_halt_enable,
    .status_word_load, .stack_check_enable, .transfer_active, .bus_ctl_type,
    .bus_sync_gate, .increment_inhibit_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mfd_rom_model mfd_rom_model_i (.next_step_pointer, .rom_word);

  // ==========================================
  // Clock, compare and bus tasks
  always #12.5 ref_clk = ~ref_clk;
  task chk(input string nm, input logic [37:0] exp, input logic [37:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] d, logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [3:0] a, input logic [31:0] ed, logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rdata", {er, ed}, {s_axi_rresp, s_axi_rdata});
    s_axi_rready <= 1'b0;
  endtask
  // One step pulse, then pointer and fetched outputs settle
  task step(input logic [7:0] ep);
    @(posedge ref_clk);
    step_end <= 1'b1;
    @(posedge ref_clk);
    step_end <= 1'b0;
    @(posedge ref_clk);
    chk("pointer", ep, next_step_pointer);
    @(posedge ref_clk);
  endtask
  function automatic logic [37:0] mk(input logic [7:0] k);
    logic [7:0] l;
    l = k + 8'h05;
    return {k[0], k[1], l[3:0], k[1:0], k[5:0], k[0], k[1:0], k[1],
            k[1:0], k[2], k[2:0], k[1:0], k[0], 1'b0, k[1:0], k + 8'h01};
  endfunction

  // ==========================================
  // Scenarios
  task t_regs;
    axi_rd(`MFD_A_CTRL, 32'h0, `MFD_RESP_OKAY);
    axi_rd(4'h2, 32'h0, `MFD_RESP_DECERR);
    axi_wr(4'h6, 32'h1, `MFD_RESP_DECERR);
    axi_wr(`MFD_A_STATUS, 32'hffff_ffff, `MFD_RESP_OKAY);
    axi_wr(`MFD_A_CTRL, 32'h1, `MFD_RESP_OKAY);
    axi_rd(`MFD_A_CTRL, 32'h1, `MFD_RESP_OKAY);
    axi_wr(`MFD_A_CTRL, 32'h2, `MFD_RESP_OKAY);
    axi_rd(`MFD_A_CTRL, 32'h0, `MFD_RESP_OKAY);
    axi_rd(`MFD_A_WORD_LO, 32'h1, `MFD_RESP_OKAY);
  endtask
  task t_steps;
    logic [7:0] k;
    logic [3:0] sa;
    for (k = 8'h01; k <= 8'h08; k++) begin
      step(k);
      sa = k[1] ? (k[0] ? k[3:0] + 4'h5 : 4'h5) : (k[0] ? 4'h7 : 4'h9);
      chk("strobes", {k == 2, k == 3, k == 4, k == 5, k == 6},
          {dest_branch_strobe, flag_load, bus_fault_halt_enable,
           status_word_load,
           stack_check_enable});
      chk("scratch", {k[1:0], k[1:0] != 0, k[1], k[1:0] == 2},
          {scratch_op_select, scratch_write, scratch_write_high,
           scratch_extra_enable});
      chk("xfer", {k[2], k[1:0]},
          {transfer_active, bus_ctl_type});
      chk("bytegate", {1'b1, k[2]},
          {increment_inhibit_n, bus_sync_gate});
      chk("apath", {k[1:0], k[1:0]},
          {a_path_select, shift_reg_op_select});
      chk("spaddr", sa, scratch_addr);
      chk("widen", k[0] ? 16'hff80 : 16'h0080, shift_reg_widened);
      chk("misc", {k[0], k[0], k[1], k[5:0]},
          {service_enable, opcode_latch_load, aux_rom_enable,
           alu_ctrl});
    end
    shift_or_bits <= 2'h1;
    @(posedge ref_clk);
    chk("shift_or", 2'h1, shift_reg_op_select);
    shift_or_bits <= 2'h0;
    axi_rd(`MFD_A_WORD_HI, 32'h0000_000d, `MFD_RESP_OKAY);
  endtask
  task t_branch;
    step(8'h09);
    axi_rd(`MFD_A_STATUS, 32'h0040_0009, `MFD_RESP_OKAY);
    byte_op <= 1'b1;
    odd_byte <= 1'b1;
    test_or_bits <= 8'h40;
    @(posedge ref_clk);
    chk("bytegate", 2'b01, {increment_inhibit_n, bus_sync_gate});
    step(8'h53);
    odd_byte <= 1'b0;
    test_or_bits <= 8'h00;
    step(8'h00);
    byte_op <= 1'b0;
    axi_rd(`MFD_A_STATUS, 32'h0, `MFD_RESP_OKAY);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    #1;
    for (int i = 0; i <= 8; i++) mfd_rom_model_i.mem[i] = mk(i[7:0]);
    mfd_rom_model_i.mem[9] = 38'h00_0012_0410;
    mfd_rom_model_i.mem[8'h53] = 38'h00_0000_04fe;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs;
    t_steps;
    t_branch;
    test_done;
  end
  initial begin
    #100000;
    err_total++;
    test_done;
  end
endmodule

// >>> dv/mfd_rom_model.sv
// Microprogram store model feeding the decoder
`timescale 1ns/1ps
module mfd_rom_model #(
  parameter W_BITS = 38
) (
  // Step address in, word out
  input  wire [7:0]        next_step_pointer,
  output wire [W_BITS-1:0] rom_word
);
  // ==========================================
  // Store, cleared at start so no word is unknown
  logic [W_BITS-1:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = '0;
    end
  end
  // Asynchronous read at the eight-bit step address
  assign rom_word = mem[next_step_pointer];
endmodule

// >>> logic/mfd_defs.vh
// Microword field layout, register map and reset values
`ifndef MFD_DEFS_VH
`define MFD_DEFS_VH

// ==========================================
// Microword field positions
`define MFD_W_BITS      38
`define MFD_F_NEXT_LO   0
`define MFD_F_NEXT_HI   7
`define MFD_F_SPOP_LO   8
`define MFD_F_SPOP_HI   9
`define MFD_F_BYTEBR    10
`define MFD_F_SERV      11
`define MFD_F_SHOP_LO   12
`define MFD_F_SHOP_HI   13
`define MFD_F_STRB_LO   14
`define MFD_F_STRB_HI   16
`define MFD_F_XFER      17
`define MFD_F_XTYP_LO   18
`define MFD_F_XTYP_HI   19
`define MFD_F_ALBYTE    20
`define MFD_F_APATH_LO  21
`define MFD_F_APATH_HI  22
`define MFD_F_SIGNW     23
`define MFD_F_ALU_LO    24
`define MFD_F_ALU_HI    29
`define MFD_F_SASRC_LO  30
`define MFD_F_SASRC_HI  31
`define MFD_F_SALIT_LO  32
`define MFD_F_SALIT_HI  35
`define MFD_F_AUX       36
`define MFD_F_IRLD      37

// ==========================================
// Field codes
`define MFD_SP_READ     2'b00
`define MFD_SP_WR_LOW   2'b01
`define MFD_SP_WR_EXT   2'b10
`define MFD_SP_WR_WORD  2'b11
`define MFD_ST_DEST     3'h2
`define MFD_ST_FLAG     3'h3
`define MFD_ST_HALT     3'h4
`define MFD_ST_PSW      3'h5
`define MFD_ST_STACK    3'h6
`define MFD_BR_EVEN     8'h02
`define MFD_BR_ODD      8'h03

// ==========================================
// Register map
`define MFD_A_CTRL      4'h0
`define MFD_A_STATUS    4'h4
`define MFD_A_WORD_LO   4'h8
`define MFD_A_WORD_HI   4'hc
`define MFD_CTRL_FREEZE 0
`define MFD_CTRL_CLEAR  1
`define MFD_CTRL_RST    2'h0
`define MFD_RESP_OKAY   2'b00
`define MFD_RESP_DECERR 2'b11

`endif

// >>> logic/mfd_microword_decoder.v
// Microword field decoder with next-step pointer and AXI4-Lite status
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mfd_defs.vh"
module mfd_microword_decoder #(
  parameter W_BITS = `MFD_W_BITS
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              rstn,
  // Microsequencer side
  input  wire [W_BITS-1:0] rom_word,
  input  wire              step_end,
  input  wire [7:0]        test_or_bits,
  input  wire              byte_op,
  input  wire              odd_byte,
  output reg  [7:0]        next_step_pointer,
  // Datapath inputs
  input  wire [1:0]        shift_or_bits,
  input  wire [3:0]        bus_addr_low,
  input  wire [15:0]       opcode,
  input  wire [15:0]       shift_reg_data,
  // Datapath controls
  output reg  [1:0]        scratch_op_select,
  output reg               scratch_write,
  output reg               scratch_write_high,
  output reg               scratch_extra_enable,
  output wire [1:0]        shift_reg_op_select,
  output reg  [1:0]        a_path_select,
  output reg               sign_widen_enable,
  output wire [15:0]       shift_reg_widened,
  output reg  [5:0]        alu_ctrl,
  output reg  [1:0]        scratch_addr_source,
  output reg  [3:0]        scratch_addr_literal,
  output reg  [3:0]        scratch_addr,
  output reg               opcode_latch_load,
  output reg               aux_rom_enable,
  // Status and trap side
  output reg               service_enable,
  output reg               dest_branch_strobe,
  output reg               flag_load,
  output reg               bus_fault_halt_enable,
  output reg               status_word_load,
  output reg               stack_check_enable,
  // Bus transfer side
  output reg               transfer_active,
  output reg  [1:0]        bus_ctl_type,
  output wire              bus_sync_gate,
  output wire              increment_inhibit_n,
  // AXI4-Lite write
  input  wire [3:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read
  input  wire [3:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  // ==========================================
  // Declarations
  reg  [W_BITS-1:0] word_r;
  reg               fetch_r;
  reg  [1:0]        ctrl_r;
  reg               clear_r;
  reg  [1:0]        shift_mode_r;
  reg               aw_held_r;
  reg  [3:0]        aw_addr_r;
  reg               w_held_r;
  reg  [31:0]       w_data_r;
  reg  [3:0]        w_strb_r;
  reg  [7:0]        ptr_nxt;
  reg  [7:0]        byte_adj;
  reg  [31:0]       rd_nxt;
  reg  [1:0]        rresp_nxt;
  wire [7:0]        strobe_hot;
  wire [7:0]        cur_next;
  wire              wr_go;
  wire              freeze;
  wire [31:0]       status_word;

  // ==========================================
  // Current word fields
  assign cur_next = word_r[`MFD_F_NEXT_HI:`MFD_F_NEXT_LO];
  assign freeze   = ctrl_r[`MFD_CTRL_FREEZE];

  // Strobe decode of the select field
  // Unused codes 0, 1 and 7 light lines that nothing reads
  mfd_strobe_dec #(
    .SEL_W (3)
  ) u_strobe (
    .sel (rom_word[`MFD_F_STRB_HI:`MFD_F_STRB_LO]),
    .hot (strobe_hot)
  );

  // ==========================================
  // Next-step pointer
  // Byte branch offset, applied only on byte instructions
  always @* begin
    byte_adj = 8'h00;
    if (word_r[`MFD_F_BYTEBR] && byte_op) begin
      byte_adj = odd_byte ? `MFD_BR_ODD : `MFD_BR_EVEN;
    end
  end

  // Next address with external test bits ORed on
  // Byte offset is added first so tests can still force any line
  always @* begin
    ptr_nxt = (cur_next + byte_adj) | test_or_bits;
  end

  // Pointer latches at the end of each step
  // Freeze drops a step outright; a pulse during freeze is lost
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      next_step_pointer <= 8'h00;
      fetch_r           <= 1'b0;
    end else if (clear_r) begin
      next_step_pointer <= 8'h00;
      fetch_r           <= 1'b1;
    end else begin
      fetch_r <= step_end && !freeze;
      if (step_end && !freeze) begin
        next_step_pointer <= ptr_nxt;
      end
    end
  end

  // ==========================================
  // Field latch, one cycle after the pointer moves
  // Word and fields load together so no step sees a mixed word
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_r                <= {W_BITS{1'b0}};
      scratch_op_select     <= `MFD_SP_READ;
      scratch_write         <= 1'b0;
      scratch_write_high    <= 1'b0;
      scratch_extra_enable  <= 1'b0;
      shift_mode_r          <= 2'b00;
      a_path_select         <= 2'b00;
      sign_widen_enable     <= 1'b0;
      alu_ctrl              <= 6'h00;
      scratch_addr_source   <= 2'b00;
      scratch_addr_literal  <= 4'h0;
      opcode_latch_load     <= 1'b0;
      aux_rom_enable        <= 1'b0;
      service_enable        <= 1'b0;
      dest_branch_strobe    <= 1'b0;
      flag_load             <= 1'b0;
      bus_fault_halt_enable <= 1'b0;
      status_word_load      <= 1'b0;
      stack_check_enable    <= 1'b0;
      transfer_active       <= 1'b0;
      bus_ctl_type          <= 2'b00;
    end else if (fetch_r) begin
      word_r <= rom_word;
      // Scratch pad operation decode
      scratch_op_select <= rom_word[`MFD_F_SPOP_HI:`MFD_F_SPOP_LO];
      scratch_write <= (rom_word[`MFD_F_SPOP_HI:`MFD_F_SPOP_LO]
                        != `MFD_SP_READ);
      scratch_write_high <= rom_word[`MFD_F_SPOP_HI];
      scratch_extra_enable <= (rom_word[`MFD_F_SPOP_HI:`MFD_F_SPOP_LO]
                               == `MFD_SP_WR_EXT);
      shift_mode_r <= rom_word[`MFD_F_SHOP_HI:`MFD_F_SHOP_LO];
      a_path_select <= rom_word[`MFD_F_APATH_HI:`MFD_F_APATH_LO];
      sign_widen_enable <= rom_word[`MFD_F_SIGNW];
      alu_ctrl <= rom_word[`MFD_F_ALU_HI:`MFD_F_ALU_LO];
      scratch_addr_source <= rom_word[`MFD_F_SASRC_HI:`MFD_F_SASRC_LO];
      scratch_addr_literal <= rom_word[`MFD_F_SALIT_HI:`MFD_F_SALIT_LO];
      opcode_latch_load <= rom_word[`MFD_F_IRLD];
      aux_rom_enable <= rom_word[`MFD_F_AUX];
      service_enable <= rom_word[`MFD_F_SERV];
      // One strobe per select code; unused codes give none
      dest_branch_strobe    <= strobe_hot[`MFD_ST_DEST];
      flag_load             <= strobe_hot[`MFD_ST_FLAG];
      bus_fault_halt_enable <= strobe_hot[`MFD_ST_HALT];
      status_word_load      <= strobe_hot[`MFD_ST_PSW];
      stack_check_enable    <= strobe_hot[`MFD_ST_STACK];
      transfer_active <= rom_word[`MFD_F_XFER];
      bus_ctl_type <= rom_word[`MFD_F_XTYP_HI:`MFD_F_XTYP_LO];
    end
  end

  // ==========================================
  // Datapath helpers
  // Shift mode is ORable by other logic
  assign shift_reg_op_select = shift_mode_r | shift_or_bits;

  // Sign widening of the low byte
  // High byte is rebuilt from bit 7, old high byte is dropped
  assign shift_reg_widened = sign_widen_enable ?
    {{8{shift_reg_data[7]}}, shift_reg_data[7:0]} :
    shift_reg_data;

  // Scratch address source mux
  always @* begin
    case (scratch_addr_source)
      2'b00:   scratch_addr = bus_addr_low;
      2'b01:   scratch_addr = {1'b0, opcode[8:6]};
      2'b10:   scratch_addr = {1'b0, opcode[2:0]};
      2'b11:   scratch_addr = scratch_addr_literal;
      default: scratch_addr = 4'h0;
    endcase
  end

  // Byte transfers: sync only when byte access allowed
  // A byte cycle without the allow bit keeps sync off; a byte cycle with it
  // stops the plus-one step of the address
  assign bus_sync_gate = transfer_active &&
                         (word_r[`MFD_F_ALBYTE] || !byte_op);
  assign increment_inhibit_n = !(word_r[`MFD_F_ALBYTE] && byte_op);

  // ==========================================
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;

  // Capture address and data in either order, answer both
  // Each ready drops while its own half is held, both while answered, so a
  // second write simply waits until the response is taken
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r    <= 1'b0;
      aw_addr_r    <= 4'h0;
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MFD_RESP_OKAY;
      ctrl_r       <= `MFD_CTRL_RST;
      clear_r      <= 1'b0;
    end else begin
      clear_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `MFD_RESP_OKAY;
        case (aw_addr_r[3:2])
          2'b00: begin
            if (w_strb_r[0]) begin
              ctrl_r[`MFD_CTRL_FREEZE] <= w_data_r[`MFD_CTRL_FREEZE];
              clear_r <= w_data_r[`MFD_CTRL_CLEAR];
            end
          end
          2'b01, 2'b10, 2'b11: begin
          end
          default: s_axi_bresp <= `MFD_RESP_DECERR;
        endcase
        if (aw_addr_r[1:0] != 2'b00) begin
          s_axi_bresp <= `MFD_RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Status word seen by software
  // Pointer in the low byte, one bit per strobe above it
  assign status_word = {8'h00,
                        service_enable,
                        transfer_active,
                        bus_ctl_type,
                        dest_branch_strobe,
                        flag_load,
                        bus_fault_halt_enable,
                        status_word_load,
                        stack_check_enable,
                        7'h00,
                        next_step_pointer};

  // ==========================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  // Read data mux
  always @* begin
    rd_nxt    = 32'h0000_0000;
    rresp_nxt = `MFD_RESP_OKAY;
    case (s_axi_araddr)
      `MFD_A_CTRL:    rd_nxt = {30'h0000_0000, 1'b0, freeze};
      `MFD_A_STATUS:  rd_nxt = status_word;
      `MFD_A_WORD_LO: rd_nxt = word_r[31:0];
      `MFD_A_WORD_HI: rd_nxt = {{(64-W_BITS){1'b0}}, word_r[W_BITS-1:32]};
      default:        rresp_nxt = `MFD_RESP_DECERR;
    endcase
  end

  // Register the answer at the edge that takes the address
  // Arready drops only while an answer waits, so reads never overlap
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MFD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_nxt;
      s_axi_rresp  <= rresp_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> logic/mfd_strobe_dec.v
// One-hot decoder for the multiplexed branch/enable select field
`timescale 1ns/1ps
module mfd_strobe_dec #(
  parameter SEL_W = 3
) (
  // Select code
  input  wire [SEL_W-1:0]      sel,
  // One-hot result
  output wire [(1<<SEL_W)-1:0] hot
);

  // ==========================================
  // Decode
  genvar i;
  generate
    for (i = 0; i < (1 << SEL_W); i = i + 1) begin : g_code
      // One line per code value
      assign hot[i] = (sel == i[SEL_W-1:0]);
    end
  endgenerate

endmodule
